// ---- hw/iocfg_pkg.sv ----
package iocfg_pkg;
  // Configuration port protocol
  localparam logic [7:0] IOCFG_ENTER_KEY    = 8'h44;
  localparam logic [7:0] IOCFG_EXIT_KEY     = 8'haa;
  // Register indices
  localparam logic [7:0] IOCFG_IDX_PAR_SER  = 8'h04;
  localparam logic [7:0] IOCFG_IDX_FLOPPY   = 8'h05;
  // Reset values
  localparam logic [7:0] IOCFG_PAR_SER_RST  = 8'h00;
  localparam logic [7:0] IOCFG_FLOPPY_RST   = 8'h00;
  localparam logic [7:0] IOCFG_INDEX_RST    = 8'h00;
  // Writable bit masks; other bits are held at zero
  localparam logic [7:0] IOCFG_PAR_SER_MASK = 8'h33;
  localparam logic [7:0] IOCFG_FLOPPY_MASK  = 8'h7f;
  // Field positions, parallel/serial setup
  localparam int IOCFG_PAR_MODE_LSB  = 0;
  localparam int IOCFG_UART_A_BIT    = 4;
  localparam int IOCFG_UART_B_BIT    = 5;
  // Field positions, floppy/disk setup
  localparam int IOCFG_FLOPPY_ALT_BIT = 0;
  localparam int IOCFG_DISK_ALT_BIT   = 1;
  localparam int IOCFG_NONBURST_BIT   = 2;
  localparam int IOCFG_DENSITY_LSB    = 3;
  localparam int IOCFG_SWAP_BIT       = 5;
  localparam int IOCFG_QUAD_BIT       = 6;
  // Parallel modes
  localparam logic [1:0] IOCFG_MODE_STANDARD_BIDIR = 2'h0;
  // Density overrides
  localparam logic [1:0] IOCFG_DENS_NORMAL = 2'h0;
  localparam logic [1:0] IOCFG_DENS_HIGH   = 2'h2;
  localparam logic [1:0] IOCFG_DENS_LOW    = 2'h3;
  // UART clock divisors
  localparam logic [3:0] IOCFG_DIV_NORMAL = 4'hd;
  localparam logic [3:0] IOCFG_DIV_MIDI   = 4'hc;
  // I/O decode bases
  localparam logic [9:0] IOCFG_FLOPPY_PRI = 10'h3f0;
  localparam logic [9:0] IOCFG_FLOPPY_SEC = 10'h370;
  localparam logic [9:0] IOCFG_DISK_PRI   = 10'h1f0;
  localparam logic [9:0] IOCFG_DISK_SEC   = 10'h170;
  localparam logic [9:0] IOCFG_DISK_CTL_PRI = 10'h3f6;
  localparam logic [9:0] IOCFG_DISK_CTL_SEC = 10'h376;
  // Config port state
  typedef enum logic [1:0] {
    IOCFG_IDLE  = 2'b00,
    IOCFG_KEY1  = 2'b01,
    IOCFG_ACTIVE = 2'b10
  } iocfg_state_t;
endpackage

// ---- hw/iocfg_regs.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - Index 04h register reachable only in config mode; resets to 00h
// - Index 05h register reachable only in config mode; resets to 00h
// - Parallel mode 00 is standard/bidirectional when qualifier low
// - Bits 2,3,6,7 of parallel/serial setup read as zero
// - Bit 4 sets first UART divisor: 13 low, 12 high
// - Bit 5 sets second UART divisor: 13 low, 12 high
// - MIDI divisor 12 gives 2 MHz from 24 MHz master clock
// - Bit 0 moves floppy decode from 3F0-3F7 to 370-377
// - Bit 1 moves disk decode from 1F0-1F7/3F6-7 to 170-177/376-7
// - Bit 2 picks non-burst DMA, request pulses per byte while FDD_FIFO_ON is high
// - Bit 5 swaps drive and motor selects 0 and 1
// - Bit 6 selects encoded selects for external 2-to-4 decoder
module iocfg_regs (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Config port access (index port and data port)
  input  wire logic       IO_WR,
  input  wire logic       IO_RD,
  input  wire logic       IO_INDEX_SEL,
  input  wire logic [7:0] IO_WDATA,
  output logic      [7:0] IO_RDATA,
  output logic            CONFIG_ACTIVE,
  // I/O decode
  input  wire logic [9:0] IO_ADDR,
  output logic            FLOPPY_DECODE,
  output logic            DISK_DECODE,
  // Parallel port
  input  wire logic       PAR_MODE_QUAL,
  output logic            PAR_STANDARD_BIDIR,
  output logic      [1:0] PAR_MODE,
  // UART clock enables
  output logic            UART_A_CLK_EN,
  output logic            UART_B_CLK_EN,
  // Floppy side
  input  wire logic       DENSITY_IN,
  output logic            DENSITY_OUT,
  input  wire logic [1:0] FDD_DRIVE_SEL,
  input  wire logic [3:0] FDD_MOTOR_IN,
  output logic      [3:0] FDD_DRIVE_EN,
  output logic      [3:0] FDD_MOTOR_EN,
  input  wire logic       FDD_BYTE_DONE,
  input  wire logic       FDD_DMA_REQ_IN,
  input  wire logic       FDD_FIFO_ON,
  output logic            FLOPPY_NONBURST_SEL,
  output logic            FLOPPY_DMA_REQUEST
);
  import iocfg_pkg::*;

  iocfg_state_t st_reg;
  iocfg_state_t st_next;
  logic [7:0]   index_reg;
  logic [7:0]   index_next;
  logic [7:0]   parser_reg;
  logic [7:0]   parser_next;
  logic [7:0]   floppy_reg;
  logic [7:0]   floppy_next;
  logic [7:0]   rdata_reg;
  logic [7:0]   rdata_next;
  logic         cfg_on;
  logic [1:0]   dsel;
  logic [3:0]   mot;
  logic [3:0]   drv_next;
  logic [3:0]   mot_next;
  logic [3:0]   drv_reg;
  logic [3:0]   mot_reg;
  logic         dens_next;
  logic         dens_reg;
  logic         req_next;
  logic         req_reg;
  logic         fsec;
  logic         dsec;

  assign cfg_on = (st_reg == IOCFG_ACTIVE);

  // Key sequence and register access
  always_comb begin
    st_next     = st_reg;
    index_next  = index_reg;
    parser_next = parser_reg;
    floppy_next = floppy_reg;
    rdata_next  = rdata_reg;
    unique case (st_reg)
      IOCFG_IDLE: begin
        if (IO_WR && IO_INDEX_SEL && IO_WDATA == IOCFG_ENTER_KEY) begin
          st_next = IOCFG_KEY1;
        end
      end
      IOCFG_KEY1: begin
        // Any other access in between breaks the key
        if (IO_WR || IO_RD) begin
          if (IO_WR && IO_INDEX_SEL && IO_WDATA == IOCFG_ENTER_KEY) begin
            st_next = IOCFG_ACTIVE;
          end else begin
            st_next = IOCFG_IDLE;
          end
        end
      end
      IOCFG_ACTIVE: begin
        if (IO_WR && IO_INDEX_SEL) begin
          if (IO_WDATA == IOCFG_EXIT_KEY) begin
            st_next = IOCFG_IDLE;
          end else begin
            index_next = IO_WDATA;
          end
        end else if (IO_WR) begin
          if (index_reg == IOCFG_IDX_PAR_SER) begin
            parser_next = IO_WDATA & IOCFG_PAR_SER_MASK;
          end
          if (index_reg == IOCFG_IDX_FLOPPY) begin
            floppy_next = IO_WDATA & IOCFG_FLOPPY_MASK;
          end
        end
      end
      default: st_next = IOCFG_IDLE;
    endcase
    // Reads return zero outside config mode
    if (IO_RD && cfg_on && IO_INDEX_SEL) begin
      rdata_next = index_reg;
    end else if (IO_RD && cfg_on && index_reg == IOCFG_IDX_PAR_SER) begin
      rdata_next = parser_reg;
    end else if (IO_RD && cfg_on && index_reg == IOCFG_IDX_FLOPPY) begin
      rdata_next = floppy_reg;
    end else if (IO_RD) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg     <= IOCFG_IDLE;
      index_reg  <= IOCFG_INDEX_RST;
      parser_reg <= IOCFG_PAR_SER_RST;
      floppy_reg <= IOCFG_FLOPPY_RST;
      rdata_reg  <= 8'h00;
    end else begin
      st_reg     <= st_next;
      index_reg  <= index_next;
      parser_reg <= parser_next;
      floppy_reg <= floppy_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign IO_RDATA      = rdata_reg;
  assign CONFIG_ACTIVE = cfg_on;

  assign fsec = floppy_reg[IOCFG_FLOPPY_ALT_BIT];
  assign FLOPPY_DECODE = (IO_ADDR[9:3] ==
    (fsec ? IOCFG_FLOPPY_SEC[9:3] : IOCFG_FLOPPY_PRI[9:3]));

  assign dsec = floppy_reg[IOCFG_DISK_ALT_BIT];
  assign DISK_DECODE =
    (IO_ADDR[9:3] == (dsec ? IOCFG_DISK_SEC[9:3] : IOCFG_DISK_PRI[9:3])) ||
    (IO_ADDR[9:1] ==
      (dsec ? IOCFG_DISK_CTL_SEC[9:1] : IOCFG_DISK_CTL_PRI[9:1]));

  assign PAR_MODE = parser_reg[IOCFG_PAR_MODE_LSB +: 2];
  assign PAR_STANDARD_BIDIR = !PAR_MODE_QUAL &&
    (PAR_MODE == IOCFG_MODE_STANDARD_BIDIR);

  // first UART divisor; 12 gives 2 MHz
  iocfg_uart_div u_div_a (
    .clk      (CLK),
    .rst      (RST),
    .midi_sel (parser_reg[IOCFG_UART_A_BIT]),
    .clk_en   (UART_A_CLK_EN)
  );

  iocfg_uart_div u_div_b (
    .clk      (CLK),
    .rst      (RST),
    .midi_sel (parser_reg[IOCFG_UART_B_BIT]),
    .clk_en   (UART_B_CLK_EN)
  );

  // Floppy drive and motor mapping, density, DMA style
  always_comb begin
    dsel = FDD_DRIVE_SEL;
    mot  = FDD_MOTOR_IN;
    if (floppy_reg[IOCFG_SWAP_BIT]) begin
      if (dsel[1] == 1'b0) begin
        dsel[0] = ~dsel[0];
      end
      mot = {FDD_MOTOR_IN[3:2], FDD_MOTOR_IN[0], FDD_MOTOR_IN[1]};
    end
    if (floppy_reg[IOCFG_QUAD_BIT]) begin
      drv_next = {2'b00, dsel};
    end else begin
      drv_next = 4'h1 << dsel;
    end
    mot_next = mot;
    unique case (floppy_reg[IOCFG_DENSITY_LSB +: 2])
      IOCFG_DENS_HIGH: dens_next = 1'b1;
      IOCFG_DENS_LOW:  dens_next = 1'b0;
      default:         dens_next = DENSITY_IN;
    endcase
    // one pulse per byte when non-burst and FDD_FIFO_ON is high
    if (floppy_reg[IOCFG_NONBURST_BIT] && FDD_FIFO_ON) begin
      req_next = FDD_BYTE_DONE;
    end else begin
      req_next = FDD_DMA_REQ_IN;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      drv_reg  <= 4'h0;
      mot_reg  <= 4'h0;
      dens_reg <= 1'b0;
      req_reg  <= 1'b0;
    end else begin
      drv_reg  <= drv_next;
      mot_reg  <= mot_next;
      dens_reg <= dens_next;
      req_reg  <= req_next;
    end
  end

  assign FDD_DRIVE_EN        = drv_reg;
  assign FDD_MOTOR_EN        = mot_reg;
  assign DENSITY_OUT         = dens_reg;
  assign FLOPPY_DMA_REQUEST  = req_reg;
  assign FLOPPY_NONBURST_SEL = floppy_reg[IOCFG_NONBURST_BIT];
endmodule // iocfg_regs

// ---- hw/iocfg_uart_div.sv ----
`timescale 1ns/10ps
// Divides the master clock by 13 or 12 into a one-cycle enable
module iocfg_uart_div (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       midi_sel,
  // Output
  output logic            clk_en
);
  import iocfg_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       en_reg;
  logic       en_next;
  logic [3:0] div;

  always_comb begin
    div = midi_sel ? IOCFG_DIV_MIDI : IOCFG_DIV_NORMAL;
    // Switch applies to the running count at once, no short pulse
    if (cnt_reg >= div - 4'h1) begin
      cnt_next = 4'h0;
      en_next  = 1'b1;
    end else begin
      cnt_next = cnt_reg + 4'h1;
      en_next  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      en_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      en_reg  <= en_next;
    end
  end

  assign clk_en = en_reg;
endmodule // iocfg_uart_div

// ---- tb/io_extended_setup_config_tb_top.sv ----
`timescale 1ns/10ps
module io_extended_setup_config_tb_top;
  logic       CLK = 1'b0, RST = 1'b1, IO_WR, IO_RD, IO_INDEX_SEL;
  logic [7:0] IO_WDATA, IO_RDATA, v;
  logic [9:0] IO_ADDR;
  logic       CONFIG_ACTIVE, FLOPPY_DECODE, DISK_DECODE, PAR_MODE_QUAL;
  logic       PAR_STANDARD_BIDIR, UART_A_CLK_EN, UART_B_CLK_EN, rd_q;
  logic [1:0] PAR_MODE, FDD_DRIVE_SEL;
  logic       DENSITY_IN, DENSITY_OUT, FDD_BYTE_DONE, FDD_DMA_REQ_IN;
  logic       FDD_FIFO_ON, FLOPPY_NONBURST_SEL, FLOPPY_DMA_REQUEST, fe, de;
  logic [3:0] FDD_MOTOR_IN, FDD_DRIVE_EN, FDD_MOTOR_EN;
  logic [9:0] al [6] = '{10'h3f2, 10'h372, 10'h1f5, 10'h176, 10'h3f7,
                         10'h377};
  logic [31:0] seed = 32'h63;
  logic [7:0]  expq [$];
  int          fail_count = 0, cmp_count = 0;
  always #2.5 CLK = ~CLK;
  iocfg_regs dut (.CLK, .RST, .IO_WR, .IO_RD, .IO_INDEX_SEL, .IO_WDATA,
    .IO_RDATA, .CONFIG_ACTIVE, .IO_ADDR, .FLOPPY_DECODE, .DISK_DECODE,
    .PAR_MODE_QUAL, .PAR_STANDARD_BIDIR, .PAR_MODE, .UART_A_CLK_EN,
    .UART_B_CLK_EN, .DENSITY_IN, .DENSITY_OUT, .FDD_DRIVE_SEL,
    .FDD_MOTOR_IN, .FDD_DRIVE_EN, .FDD_MOTOR_EN, .FDD_BYTE_DONE,
    .FDD_DMA_REQ_IN, .FDD_FIFO_ON, .FLOPPY_NONBURST_SEL,
    .FLOPPY_DMA_REQUEST);
  iocfg_host host (.CLK, .IO_WR, .IO_RD, .IO_INDEX_SEL, .IO_WDATA);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Read data lands the cycle after the strobe
  always @(posedge CLK) rd_q <= IO_RD;
  always @(negedge CLK) if (rd_q) chk(IO_RDATA, expq.pop_front());
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    host.acc(1'b0, 1'b1, i);
    expq.push_back(e);
    host.acc(1'b1, 1'b0, 8'h00);
  endtask
  task automatic per(input logic b, input logic [7:0] e);
    logic [7:0] n;
    for (int k = 0; k < 2; k++) begin
      n = 8'h00;
      do begin @(negedge CLK); n++; end
      while (!(b ? UART_B_CLK_EN : UART_A_CLK_EN) && n < 30);
    end
    chk(n, e);
  endtask
  task automatic fcase(input logic [7:0] r, input logic [6:0] in,
                       input logic [7:0] e, input logic ed);
    {DENSITY_IN, FDD_DRIVE_SEL, FDD_MOTOR_IN} = in;
    host.wreg(8'h05, r);
    host.idle();
    chk({FDD_DRIVE_EN, FDD_MOTOR_EN}, e);
    chk({7'h00, DENSITY_OUT}, {7'h00, ed});
  endtask
  task results;
    $display("checks %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    results();
  end
  initial begin
    {IO_ADDR, PAR_MODE_QUAL, DENSITY_IN, FDD_DRIVE_SEL} = '0;
    {FDD_MOTOR_IN, FDD_BYTE_DONE, FDD_DMA_REQ_IN, FDD_FIFO_ON} = '0;
    repeat (10) @(posedge CLK);
    #1 RST = 1'b0;
    host.wreg(8'h04, 8'hff);
    rd(8'h04, 8'h00);
    host.enter();
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    host.wreg(8'h04, 8'hff);
    chk({6'h00, PAR_MODE}, 8'h03);
    chk({7'h00, PAR_STANDARD_BIDIR}, 8'h00);
    rd(8'h04, 8'h33);
    repeat (4) begin
      v = rnd();
      host.wreg(8'h04, v);
      chk({6'h00, PAR_MODE}, {6'h00, v[1:0]});
      chk({7'h00, PAR_STANDARD_BIDIR}, {7'h00, v[1:0] == 2'b00});
      rd(8'h04, v & 8'h33);
      v = rnd();
      host.wreg(8'h05, v);
      rd(8'h05, v & 8'h7f);
    end
    host.wreg(8'h06, 8'h5a);
    rd(8'h06, 8'h00);
    // Index port reads back the selected index
    expq.push_back(8'h06);
    host.acc(1'b1, 1'b1, 8'h00);
    for (int r = 0; r < 4; r++) begin
      host.wreg(8'h05, r[7:0]);
      foreach (al[j]) begin
        IO_ADDR = al[j];
        host.idle();
        fe = al[j][9:3] == (r[0] ? 7'h6e : 7'h7e);
        de = al[j][9:3] == (r[1] ? 7'h2e : 7'h3e) ||
             al[j][9:1] == (r[1] ? 9'h1bb : 9'h1fb);
        chk({6'h00, FLOPPY_DECODE, DISK_DECODE}, {6'h00, fe, de});
      end
    end
    fcase(8'h00, 7'h61, 8'h41, 1'b1);
    fcase(8'h10, 7'h02, 8'h12, 1'b1);
    fcase(8'h18, 7'h52, 8'h22, 1'b0);
    fcase(8'h00, 7'h38, 8'h88, 1'b0);
    fcase(8'h20, 7'h01, 8'h22, 1'b0);
    fcase(8'h20, 7'h12, 8'h11, 1'b0);
    fcase(8'h40, 7'h64, 8'h24, 1'b1);
    host.wreg(8'h05, 8'h04);
    {FDD_FIFO_ON, FDD_DMA_REQ_IN, FDD_BYTE_DONE} = 3'b111;
    host.idle();
    chk({7'h00, FLOPPY_NONBURST_SEL}, 8'h01);
    chk({7'h00, FLOPPY_DMA_REQUEST}, 8'h01);
    FDD_BYTE_DONE = 1'b0;
    host.idle();
    chk({7'h00, FLOPPY_DMA_REQUEST}, 8'h00);
    host.wreg(8'h04, 8'h10);
    per(1'b0, 8'd12);
    per(1'b1, 8'd13);
    host.wreg(8'h04, 8'h20);
    per(1'b0, 8'd13);
    per(1'b1, 8'd12);
    PAR_MODE_QUAL = 1'b1;
    host.idle();
    chk({7'h00, PAR_STANDARD_BIDIR}, 8'h00);
    PAR_MODE_QUAL = 1'b0;
    host.idle();
    chk({7'h00, PAR_STANDARD_BIDIR}, 8'h01);
    host.acc(1'b0, 1'b1, 8'haa);
    rd(8'h05, 8'h00);
    chk({7'h00, CONFIG_ACTIVE}, 8'h00);
    repeat (2) host.idle();
    results();
  end
endmodule // io_extended_setup_config_tb_top
bind iocfg_regs iocfg_regs_props u_props (.CLK, .RST, .IO_WR, .IO_RD,
  .IO_INDEX_SEL, .IO_WDATA, .IO_RDATA, .CONFIG_ACTIVE, .IO_ADDR,
  .FLOPPY_DECODE, .DISK_DECODE, .UART_A_CLK_EN, .UART_B_CLK_EN);

// ---- tb/iocfg_host.sv ----
`timescale 1ns/10ps
module iocfg_host (
  // Clock
  input wire logic CLK,
  // Config port
  output logic       IO_WR,
  output logic       IO_RD,
  output logic       IO_INDEX_SEL,
  output logic [7:0] IO_WDATA
);
  initial {IO_WR, IO_RD, IO_INDEX_SEL, IO_WDATA} = '0;
  // Held through the sampling edge, one access a cycle
  task automatic acc(input logic rd, input logic ix, input logic [7:0] d);
    IO_WR = !rd;
    IO_RD = rd;
    IO_INDEX_SEL = ix;
    IO_WDATA = d;
    @(posedge CLK);
    #1;
  endtask
  // Released data shows no stale byte
  task automatic idle;
    IO_WR = 1'b0;
    IO_RD = 1'b0;
    IO_WDATA = ~IO_WDATA;
    @(posedge CLK);
    #1;
  endtask
  task automatic enter;
    acc(1'b0, 1'b1, 8'h44);
    acc(1'b0, 1'b1, 8'h44);
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    acc(1'b0, 1'b1, i);
    acc(1'b0, 1'b0, d);
  endtask
endmodule // iocfg_host

// ---- tb/iocfg_regs_properties.sv ----
`timescale 1ns/10ps
module iocfg_regs_props (
  // Watched ports
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       IO_WR,
  input wire logic       IO_RD,
  input wire logic       IO_INDEX_SEL,
  input wire logic [7:0] IO_WDATA,
  input wire logic [7:0] IO_RDATA,
  input wire logic       CONFIG_ACTIVE,
  input wire logic [9:0] IO_ADDR,
  input wire logic       FLOPPY_DECODE,
  input wire logic       DISK_DECODE,
  input wire logic       UART_A_CLK_EN,
  input wire logic       UART_B_CLK_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic k44;
  logic kaa;
  assign k44 = IO_WR && IO_INDEX_SEL && IO_WDATA == 8'h44;
  assign kaa = IO_WR && IO_INDEX_SEL && IO_WDATA == 8'haa;
  a_key_enter: assert property (k44 ##1 k44 |=> CONFIG_ACTIVE)
    else $error("two keys did not enter");
  a_entry_cause: assert property ($rose(CONFIG_ACTIVE) |->
    $past(k44) && $past(k44, 2)) else $error("entry without keys");
  a_key_exit: assert property (kaa |=> !CONFIG_ACTIVE)
    else $error("exit key ignored");
  a_idle_read: assert property (IO_RD && !IO_INDEX_SEL &&
    !CONFIG_ACTIVE |=> IO_RDATA == 8'h00) else $error("idle read");
  a_rdata_hold: assert property (!IO_RD |=> $stable(IO_RDATA))
    else $error("read data moved");
  a_floppy_range: assert property (FLOPPY_DECODE |->
    IO_ADDR[9:3] inside {7'h7e, 7'h6e}) else $error("floppy decode");
  a_disk_range: assert property (DISK_DECODE |->
    (IO_ADDR[9:3] inside {7'h3e, 7'h2e}) ||
    (IO_ADDR[9:1] inside {9'h1fb, 9'h1bb})) else $error("disk decode");
  a_uart_a_gap: assert property (UART_A_CLK_EN |->
    ##[1:16] UART_A_CLK_EN) else $error("uart a enable stalled");
  a_uart_b_gap: assert property (UART_B_CLK_EN |->
    ##[1:16] UART_B_CLK_EN) else $error("uart b enable stalled");
endmodule // iocfg_regs_props
